// ===== logic/tfs_pkg.sv
// shared constants and types for the timer freeze and system control bank
package tfs_pkg;

	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 32;
	localparam int NUM_TIMERS = 4;
	localparam int MAP_W      = 5;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_SILICON_REVISION     = 32'h5000_3204;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_FREEZE_SET     = 32'h5000_3300;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_FREEZE_RELEASE = 32'h5000_3302;
	localparam logic [ADDR_W-1:0] ADDR_DEBUG_HALT_POLICY    = 32'h5000_3304;
	localparam logic [ADDR_W-1:0] ADDR_GENERAL_STATUS       = 32'h5000_3306;
	localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONTROL      = 32'h5000_3308;

	// field positions
	localparam int HALT_WATCHDOG_BIT          = 3;
	localparam int HALT_LINK_MASTER_CLOCK_BIT = 2;
	localparam int HALT_SOFTWARE_TIMER_BIT    = 1;
	localparam int HALT_WAKE_TIMER_BIT        = 0;
	localparam int DEBUG_HALT_ENABLE_BIT      = 0;
	localparam int CALIBRATION_PHASE_BIT      = 0;
	localparam int WAKE_REQUEST_BIT           = 0;
	localparam int MEMORY_SPLIT_LSB           = 1;
	localparam int MEMORY_SPLIT_MSB           = 5;
	localparam int REVISION_MSB               = 7;

	// reset values
	localparam logic [NUM_TIMERS-1:0] FREEZE_RST         = 4'h0;
	localparam logic                  DEBUG_ENABLE_RST   = 1'b1;
	localparam logic                  CALIBRATION_RST    = 1'b0;
	localparam logic [MAP_W-1:0]      MEMORY_SPLIT_RST   = 5'h01;
	localparam logic                  WAKE_REQUEST_RST   = 1'b0;

	// memory split codes that select nothing, and the last legal code
	localparam logic [MAP_W-1:0] MEMORY_SPLIT_RESERVED_A = 5'h08;
	localparam logic [MAP_W-1:0] MEMORY_SPLIT_RESERVED_B = 5'h10;
	localparam logic [MAP_W-1:0] MEMORY_SPLIT_LAST       = 5'h17;

	// wake interrupt delay, in low-power clock periods
	localparam int WAKE_DELAY_MIN_LP = 3;
	localparam int WAKE_DELAY_MAX_LP = 4;
	localparam logic [2:0] WAKE_LP_EDGES = 3'(WAKE_DELAY_MAX_LP);

	typedef enum logic [1:0] {
		WK_IDLE,
		WK_COUNT,
		WK_FIRED
	} tfs_wake_state_t;

endpackage

// ===== logic/tfs_freeze_bit.sv
// one timer's freeze state with its debug-halt override
`timescale 1ns/1ps
module tfs_freeze_bit (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic set_req,
	input  wire logic release_req,
	input  wire logic debug_force,
	output logic      held,
	output logic      frozen
);
	import tfs_pkg::*;

	logic held_r;
	logic held_nxt;
	logic frozen_r;
	logic frozen_nxt;

	always_comb begin
		held_nxt = held_r;
		// set and release come from different writes, never together
		if (set_req) begin
			held_nxt = 1'b1;
		end else if (release_req) begin
			held_nxt = 1'b0;
		end
		frozen_nxt = held_nxt | debug_force;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			held_r   <= 1'b0;
			frozen_r <= 1'b0;
		end else begin
			held_r   <= held_nxt;
			frozen_r <= frozen_nxt;
		end
	end

	assign held   = held_r;
	assign frozen = frozen_r;

endmodule // tfs_freeze_bit

// ===== logic/tfs_wake_delay.sv
// low-power wake interrupt timing after a link wake request
`timescale 1ns/1ps
module tfs_wake_delay (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic wake_req,
	input  wire logic deep_sleep,
	input  wire logic lp_clk,
	output logic      wake_irq
);
	import tfs_pkg::*;

	tfs_wake_state_t state_r;
	tfs_wake_state_t state_nxt;
	logic [2:0]      edges_r;
	logic [2:0]      edges_nxt;
	logic            lp_q_r;
	logic            req_q_r;
	logic            irq_r;
	logic            irq_nxt;
	logic            lp_rise;
	logic            req_rise;

	// lp_clk is sampled as a plain synchronous input
	assign lp_rise  = lp_clk & ~lp_q_r;
	assign req_rise = wake_req & ~req_q_r;

	always_comb begin
		state_nxt = state_r;
		edges_nxt = edges_r;
		irq_nxt   = irq_r;
		unique case (state_r)
			WK_IDLE: begin
				irq_nxt = 1'b0;
				if (req_rise && deep_sleep) begin
					state_nxt = WK_COUNT;
					edges_nxt = 3'h0;
				end
			end
			WK_COUNT: begin
				// 4th lp edge lands 3 to 4 periods after the request
				if (!wake_req) begin
					state_nxt = WK_IDLE;
				end else if (lp_rise) begin
					edges_nxt = 3'(edges_r + 3'h1);
					if (edges_nxt == WAKE_LP_EDGES) begin
						state_nxt = WK_FIRED;
						irq_nxt   = 1'b1;
					end
				end
			end
			WK_FIRED: begin
				// held until software drops the request
				if (!wake_req) begin
					state_nxt = WK_IDLE;
					irq_nxt   = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= WK_IDLE;
			edges_r <= 3'h0;
			lp_q_r  <= 1'b0;
			req_q_r <= 1'b0;
			irq_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			edges_r <= edges_nxt;
			lp_q_r  <= lp_clk;
			req_q_r <= wake_req;
			irq_r   <= irq_nxt;
		end
	end

	assign wake_irq = irq_r;

endmodule // tfs_wake_delay

// ===== logic/tfs_sysctrl.sv
// timer freeze, debug policy and system control register bank
// Operation
// - revision register reads a fixed 8-bit version letter, writes ignored
// - freeze-set writes of 1 freeze watchdog, link clock, sw or wake timer
// - watchdog freeze request ignored while watchdog is reset-only
// - freeze-release writes of 1 resume the matching timer, 0 does nothing
// - debug enable 1 freezes all timers while the cpu is debug-halted
// - debug enable 0: non-watchdog timers follow their own freeze state
// - watchdog is always frozen while the cpu is debug-halted
// - read/write calibration-phase flag at bit 0, reset 0
// - 5-bit memory split field, reset 1, codes 8 and 16 reserved
// - wake request in deep sleep raises wake interrupt 3 to 4 lp cycles on
`timescale 1ns/1ps
module tfs_sysctrl #(
	// arbitrary neutral version letter
	parameter logic [7:0] SILICON_VERSION_LETTER = 8'h58
) (
	input  wire logic                          ref_clk,
	input  wire logic                          reset,
	input  wire logic [tfs_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [tfs_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [tfs_pkg::DATA_W-1:0]    reg_rdata,
	input  wire logic                          wdog_reset_only,
	input  wire logic                          cpu_debug_halted,
	input  wire logic                          link_deep_sleep,
	input  wire logic                          lp_clk,
	output logic                               halt_watchdog,
	output logic                               halt_link_master_clock,
	output logic                               halt_software_timer,
	output logic                               halt_wake_timer,
	output logic                               calibration_phase,
	output logic      [tfs_pkg::MAP_W-1:0]     exchange_memory_split,
	output logic                               link_layer_wake_request,
	output logic                               lp_wake_irq
);
	import tfs_pkg::*;

	// address decode
	logic hit_revision;
	logic hit_set;
	logic hit_release;
	logic hit_debug;
	logic hit_status;
	logic hit_control;

	assign hit_revision = (reg_addr == ADDR_SILICON_REVISION);
	assign hit_set      = (reg_addr == ADDR_TIMER_FREEZE_SET);
	assign hit_release  = (reg_addr == ADDR_TIMER_FREEZE_RELEASE);
	assign hit_debug    = (reg_addr == ADDR_DEBUG_HALT_POLICY);
	assign hit_status   = (reg_addr == ADDR_GENERAL_STATUS);
	assign hit_control  = (reg_addr == ADDR_GENERAL_CONTROL);

	// freeze set / release requests, one bit per timer
	logic [NUM_TIMERS-1:0] set_vec;
	logic [NUM_TIMERS-1:0] release_vec;
	logic [NUM_TIMERS-1:0] force_vec;
	logic [NUM_TIMERS-1:0] held_vec;
	logic [NUM_TIMERS-1:0] frozen_vec;

	// debug policy and general status/control state
	logic                  debug_enable_r;
	logic                  debug_enable_nxt;
	logic                  calibration_r;
	logic                  calibration_nxt;
	logic [MAP_W-1:0]      split_r;
	logic [MAP_W-1:0]      split_nxt;
	logic                  wake_req_r;
	logic                  wake_req_nxt;
	logic [MAP_W-1:0]      split_wr;
	logic                  split_legal;

	// read path
	logic [DATA_W-1:0]     rdata_r;
	logic [DATA_W-1:0]     rdata_nxt;

	always_comb begin
		set_vec     = '0;
		release_vec = '0;
		force_vec   = '0;
		if (reg_wr && hit_set) begin
			// only the four timer bits act; upper bits dropped
			set_vec = reg_wdata[NUM_TIMERS-1:0];
			// reset-only watchdog cannot be frozen by software
			if (wdog_reset_only) begin
				set_vec[HALT_WATCHDOG_BIT] = 1'b0;
			end
		end
		if (reg_wr && hit_release) begin
			release_vec = reg_wdata[NUM_TIMERS-1:0];
		end
		if (cpu_debug_halted) begin
			if (debug_enable_r) begin
				force_vec = '1;
			end
			// watchdog stops in debug halt whatever the policy
			force_vec[HALT_WATCHDOG_BIT] = 1'b1;
		end
		// with the policy off, other timers keep their own state
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
			tfs_freeze_bit u_freeze (
				.ref_clk     (ref_clk),
				.reset       (reset),
				.set_req     (set_vec[gi]),
				.release_req (release_vec[gi]),
				.debug_force (force_vec[gi]),
				.held        (held_vec[gi]),
				.frozen      (frozen_vec[gi])
			);
		end
	endgenerate

	assign halt_watchdog          = frozen_vec[HALT_WATCHDOG_BIT];
	assign halt_link_master_clock = frozen_vec[HALT_LINK_MASTER_CLOCK_BIT];
	assign halt_software_timer    = frozen_vec[HALT_SOFTWARE_TIMER_BIT];
	assign halt_wake_timer        = frozen_vec[HALT_WAKE_TIMER_BIT];

	// memory split: reserved or out-of-range codes are not taken
	assign split_wr    = reg_wdata[MEMORY_SPLIT_MSB:MEMORY_SPLIT_LSB];
	assign split_legal = (split_wr != MEMORY_SPLIT_RESERVED_A) &&
	                     (split_wr != MEMORY_SPLIT_RESERVED_B) &&
	                     (split_wr <= MEMORY_SPLIT_LAST);

	always_comb begin
		debug_enable_nxt = debug_enable_r;
		calibration_nxt  = calibration_r;
		split_nxt        = split_r;
		wake_req_nxt     = wake_req_r;
		if (reg_wr && hit_debug) begin
			debug_enable_nxt = reg_wdata[DEBUG_HALT_ENABLE_BIT];
		end
		if (reg_wr && hit_status) begin
			calibration_nxt = reg_wdata[CALIBRATION_PHASE_BIT];
		end
		if (reg_wr && hit_control) begin
			if (split_legal) begin
				split_nxt = split_wr;
			end
			// hold time on this bit is software's job
			wake_req_nxt = reg_wdata[WAKE_REQUEST_BIT];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			debug_enable_r <= DEBUG_ENABLE_RST;
			calibration_r  <= CALIBRATION_RST;
			split_r        <= MEMORY_SPLIT_RST;
			wake_req_r     <= WAKE_REQUEST_RST;
		end else begin
			debug_enable_r <= debug_enable_nxt;
			calibration_r  <= calibration_nxt;
			split_r        <= split_nxt;
			wake_req_r     <= wake_req_nxt;
		end
	end

	assign calibration_phase       = calibration_r;
	assign exchange_memory_split   = split_r;
	assign link_layer_wake_request = wake_req_r;

	tfs_wake_delay u_wake (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.wake_req   (wake_req_r),
		.deep_sleep (link_deep_sleep),
		.lp_clk     (lp_clk),
		.wake_irq   (lp_wake_irq)
	);

	// read data stands only in the cycle after the strobe
	always_comb begin
		rdata_nxt = '0;
		if (reg_rd) begin
			if (hit_revision) begin
				rdata_nxt[REVISION_MSB:0] = SILICON_VERSION_LETTER;
			end else if (hit_set || hit_release) begin
				rdata_nxt[NUM_TIMERS-1:0] = held_vec;
			end else if (hit_debug) begin
				rdata_nxt[DEBUG_HALT_ENABLE_BIT] = debug_enable_r;
			end else if (hit_status) begin
				rdata_nxt[CALIBRATION_PHASE_BIT] = calibration_r;
			end else if (hit_control) begin
				rdata_nxt[MEMORY_SPLIT_MSB:MEMORY_SPLIT_LSB] = split_r;
				rdata_nxt[WAKE_REQUEST_BIT] = wake_req_r;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

endmodule // tfs_sysctrl

// ===== tb/tfs_sysctrl_monitor.sv
// assertion checker for the timer freeze register bank
`timescale 1ns/1ps
module tfs_sysctrl_monitor #(
	parameter logic [7:0] SILICON_VERSION_LETTER = 8'h58
) (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [31:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        wdog_reset_only,
	input wire logic        cpu_debug_halted,
	input wire logic        link_deep_sleep,
	input wire logic        lp_clk,
	input wire logic        halt_watchdog,
	input wire logic        halt_link_master_clock,
	input wire logic        halt_software_timer,
	input wire logic        halt_wake_timer,
	input wire logic        calibration_phase,
	input wire logic [4:0]  exchange_memory_split,
	input wire logic        link_layer_wake_request,
	input wire logic        lp_wake_irq
);
	import tfs_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire wr_ctl = reg_wr && reg_addr == ADDR_GENERAL_CONTROL;
	sequence irq_start;
		$rose(lp_wake_irq);
	endsequence
	sequence wake_armed;
		$rose(link_layer_wake_request) && link_deep_sleep;
	endsequence

	rd_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
	rev_read_a: assert property (
		reg_rd && reg_addr == ADDR_SILICON_REVISION
		|=> reg_rdata == {8'h00, SILICON_VERSION_LETTER}) else $error("rev");
	wdog_set_a: assert property (
		reg_wr && reg_addr == ADDR_TIMER_FREEZE_SET && reg_wdata[3]
		&& !wdog_reset_only |=> halt_watchdog) else $error("wdog set");
	wdog_lock_a: assert property (
		$rose(halt_watchdog) |-> $past(cpu_debug_halted)
		|| ($past(reg_wr) && !$past(wdog_reset_only))) else $error("lock");
	sw_release_a: assert property (
		reg_wr && reg_addr == ADDR_TIMER_FREEZE_RELEASE && reg_wdata[1]
		&& !cpu_debug_halted |=> !halt_software_timer) else $error("rel");
	dbg_wdog_a: assert property (
		cpu_debug_halted |=> halt_watchdog) else $error("debug wdog");
	link_hold_a: assert property (
		!$past(reg_wr) && !$past(cpu_debug_halted)
		&& !$past(cpu_debug_halted, 2) |-> $stable(halt_link_master_clock))
		else $error("link halt moved");
	split_keep_a: assert property (
		wr_ctl && (reg_wdata[5:1] == 5'h08 || reg_wdata[5:1] == 5'h10)
		|=> $stable(exchange_memory_split)) else $error("split");
	irq_cause_a: assert property (
		irq_start |-> $past(link_layer_wake_request, 16)) else $error("early");
	irq_bound_a: assert property (
		wake_armed |-> ##[1:48] (lp_wake_irq || !link_layer_wake_request
		|| !link_deep_sleep)) else $error("irq late");
endmodule // tfs_sysctrl_monitor

bind tfs_sysctrl tfs_sysctrl_monitor #(
	.SILICON_VERSION_LETTER(SILICON_VERSION_LETTER)
) u_mon (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .wdog_reset_only, .cpu_debug_halted, .link_deep_sleep,
	.lp_clk, .halt_watchdog, .halt_link_master_clock, .halt_software_timer,
	.halt_wake_timer, .calibration_phase, .exchange_memory_split,
	.link_layer_wake_request, .lp_wake_irq);

// ===== tb/tfs_lp_partner.sv
// low-power clock source and link sleep state beside the bank
`timescale 1ns/1ps
module tfs_lp_partner #(
	parameter int LP_HALF = 4
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic sleep_cmd,
	output logic      lp_clk,
	output logic      link_deep_sleep
);
	int cnt;
	// free running: the slow clock never stops between wake requests
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt <= 0;
			lp_clk <= 1'b0;
		end else if (cnt == LP_HALF - 1) begin
			cnt <= 0;
			lp_clk <= ~lp_clk;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign link_deep_sleep = sleep_cmd;
endmodule // tfs_lp_partner

// ===== tb/tfs_sysctrl_tb.sv
// self-checking bench for the timer freeze register bank
`timescale 1ns/1ps
module tfs_sysctrl_tb;
	import tfs_pkg::*;
	localparam logic [7:0] LETTER = 8'h5a; // arbitrary version letter
	localparam int         LP     = 8;
	logic        ref_clk, reset, reg_wr, reg_rd, wdog_reset_only, lp_clk;
	logic        cpu_debug_halted, sleep_cmd, link_deep_sleep, lp_wake_irq;
	logic        halt_watchdog, halt_link_master_clock, halt_software_timer;
	logic        halt_wake_timer, calibration_phase, link_layer_wake_request;
	logic [31:0] reg_addr, a;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [4:0]  exchange_memory_split, m_split;
	logic [3:0]  m_held;
	logic        m_dbg, m_cal, m_wake;
	int          err_count, checks_done, cyc, n;
	logic [31:0] at [7] = '{ADDR_SILICON_REVISION, ADDR_TIMER_FREEZE_SET,
		ADDR_TIMER_FREEZE_RELEASE, ADDR_DEBUG_HALT_POLICY,
		ADDR_GENERAL_STATUS, ADDR_GENERAL_CONTROL, 32'h5000_330a};

	tfs_sysctrl #(.SILICON_VERSION_LETTER(LETTER)) uut (.ref_clk, .reset,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.wdog_reset_only, .cpu_debug_halted, .link_deep_sleep, .lp_clk,
		.halt_watchdog, .halt_link_master_clock, .halt_software_timer,
		.halt_wake_timer, .calibration_phase, .exchange_memory_split,
		.link_layer_wake_request, .lp_wake_irq);
	tfs_lp_partner #(.LP_HALF(LP / 2)) u_lp (.ref_clk, .reset, .sleep_cmd,
		.lp_clk, .link_deep_sleep);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic complete_run();
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [15:0] exp_rd(logic [31:0] x);
		case (x)
		ADDR_SILICON_REVISION: return {8'h00, LETTER};
		ADDR_TIMER_FREEZE_SET: return {12'h000, m_held};
		ADDR_TIMER_FREEZE_RELEASE: return {12'h000, m_held};
		ADDR_DEBUG_HALT_POLICY: return {15'h0000, m_dbg};
		ADDR_GENERAL_STATUS: return {15'h0000, m_cal};
		ADDR_GENERAL_CONTROL: return {10'h000, m_split, m_wake};
		default: return 16'h0000;
		endcase
	endfunction

	task automatic wr(logic [31:0] x, logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= x;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		case (x)
		ADDR_TIMER_FREEZE_SET: m_held |= v[3:0] & {~wdog_reset_only, 3'h7};
		ADDR_TIMER_FREEZE_RELEASE: m_held &= ~v[3:0];
		ADDR_DEBUG_HALT_POLICY: m_dbg = v[0];
		ADDR_GENERAL_STATUS: m_cal = v[0];
		ADDR_GENERAL_CONTROL: begin
			// reserved and out-of-range split codes keep the old split
			if (v[5:1] != 5'h08 && v[5:1] != 5'h10 && v[5:1] <= 5'h17)
				m_split = v[5:1];
			m_wake = v[0];
		end
		default: ;
		endcase
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [31:0] x);
		@(posedge ref_clk);
		reg_addr <= x;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", exp_rd(x), reg_rdata);
	endtask

	task automatic outs();
		logic [3:0] f;
		@(posedge ref_clk);
		#1;
		f = m_held | (cpu_debug_halted ? (m_dbg ? 4'hf : 4'h8) : 4'h0);
		chk("halts", {12'h000, f}, {12'h000, halt_watchdog,
			halt_link_master_clock, halt_software_timer, halt_wake_timer});
		chk("ctrl", {9'h000, m_cal, m_split, m_wake}, {9'h000,
			calibration_phase, exchange_memory_split, link_layer_wake_request});
	endtask

	task automatic quiet(string nm);
		n = 0;
		repeat (5 * LP) begin
			@(posedge ref_clk);
			#1;
			if (lp_wake_irq !== 1'b0)
				n++;
		end
		chk(nm, 16'h0000, 16'(n));
	endtask

	initial begin
		// only reset high: a stray write strobe would clobber the bank
		{reset, reg_wr, reg_rd, wdog_reset_only} = 4'h8;
		{cpu_debug_halted, sleep_cmd, reg_addr, reg_wdata} = '0;
		{m_held, m_dbg, m_cal, m_split, m_wake} = {4'h0, 2'h2, 5'h01, 1'b0};
		void'($urandom(32'hf3db));
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (at[i]) rd(at[i]);
		wr(ADDR_GENERAL_CONTROL, 16'h0010);
		wr(ADDR_GENERAL_CONTROL, 16'h0020);
		outs();
		for (int k = 0; k < 80; k++) begin
			wdog_reset_only <= 1'($urandom);
			cpu_debug_halted <= 1'($urandom);
			a = at[$urandom % 7];
			d = 16'($urandom);
			if (a == ADDR_GENERAL_CONTROL)
				d[0] = 1'b0;
			wr(a, d);
			outs();
			rd(at[$urandom % 7]);
		end
		cpu_debug_halted <= 1'b0;
		sleep_cmd <= 1'b1;
		// request held until the interrupt, well over one slow period
		wr(ADDR_GENERAL_CONTROL, {10'h000, m_split, 1'b1});
		n = 0;
		while (lp_wake_irq !== 1'b1 && n < 6 * LP) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("irq_delay", 16'(n >= 3 * LP && n <= 4 * LP + 2), 16'h1);
		wr(ADDR_GENERAL_CONTROL, {10'h000, m_split, 1'b0});
		repeat (3) @(posedge ref_clk);
		#1 chk("irq_clear", 16'h0000, {15'h0000, lp_wake_irq});
		wr(ADDR_GENERAL_CONTROL, {10'h000, m_split, 1'b1});
		repeat (LP + 1) @(posedge ref_clk);
		wr(ADDR_GENERAL_CONTROL, {10'h000, m_split, 1'b0});
		quiet("irq_abort");
		sleep_cmd <= 1'b0;
		wr(ADDR_GENERAL_CONTROL, {10'h000, m_split, 1'b1});
		quiet("irq_awake");
		outs();
		complete_run();
	end
endmodule // tfs_sysctrl_tb
